// file: nvr_pkg.sv
/*
 package of the three-channel nonvolatile resistor two-wire link: device map,
 address layout, timing counts, state and token enumerations, host registers.
 assumes a single 250 MHz clock shared by both ends.
*/
package nvr_pkg;
    // device register map
    localparam int NUM_RES = 3;
    localparam logic [7:0] REG_RES0 = 8'hF8;
    localparam logic [7:0] REG_RES1 = 8'hF9;
    localparam logic [7:0] REG_RES2 = 8'hFA;
    localparam logic [7:0] RES_DEFAULT = 8'h7F;
    localparam int HIZ_BIT = 7;
    localparam logic [7:0] SW_LOW_VALUE = 8'h00;
    // device-type field; value is arbitrary
    localparam logic [3:0] DEV_ID_DEFAULT = 4'h6;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // bit slots within one byte: eight data bits then the acknowledge
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_ACK_END = 4'h9;
    localparam logic [3:0] RECOV_LAST = 4'h8;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int NVW_TIME_MS = 20;
    localparam int NVW_CYCLES_DEFAULT = NVW_TIME_MS * 1000 * CLK_MHZ;
    localparam int SCL_KHZ = 100;
    localparam int QTR_CYCLES_DEFAULT = CLK_MHZ * 1000 / (SCL_KHZ * 4);
    // host registers
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam int CTRL_DATA_LSB = 0;
    localparam int CTRL_REG_LSB = 8;
    localparam int CTRL_SEL_LSB = 16;
    localparam int CTRL_READ_BIT = 20;
    localparam int CTRL_POLL_BIT = 21;
    localparam int CTRL_RECOV_BIT = 22;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_NACK_BIT = 2;
    localparam int STAT_RDATA_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // host sequence positions
    localparam logic [2:0] STEP_ADDR = 3'h1;
    localparam logic [2:0] STEP_REG = 3'h2;
    localparam logic [2:0] STEP_DATA = 3'h3;
    localparam logic [2:0] STEP_RADDR = 3'h4;
    localparam logic [2:0] STEP_RX = 3'h5;
    localparam logic [2:0] STEP_STOP_RC = 3'h2;
    localparam logic [2:0] STEP_STOP_WR = 3'h4;
    localparam logic [2:0] STEP_STOP_RD = 3'h6;

    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_REG, DS_DATA, DS_TX, DS_HOLD, DS_NVW
    } nvr_dstate_type;

    typedef enum logic [2:0] {
        TK_START, TK_TX, TK_RX, TK_STOP, TK_RECOV
    } nvr_token_type;
endpackage

// file: nvr_i2c_if.sv
/*
 two-wire bus between host and device: open-drain clock and data.
 assumes each end pulls its line low while its enable is high.
*/
interface nvr_i2c_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport device (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// file: nvr_line_cond.sv
/*
 line-condition detector: clock edges, start and stop from the bus levels.
 assumes scl and sda are already synchronous to aclk.
*/
module nvr_line_cond (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus levels
    input wire logic scl,
    input wire logic sda,
    // one-cycle events
    output logic scl_rise,
    output logic scl_fall,
    output logic bus_start,
    output logic bus_stop
);
    typedef struct packed {
        logic scl;
        logic sda;
    } nvr_lc_state_type;

    nvr_lc_state_type q;
    nvr_lc_state_type d;

    always_comb begin
        d.scl = scl;
        d.sda = sda;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign scl_rise = ~q.scl & scl;
    assign scl_fall = q.scl & ~scl;
    assign bus_start = q.scl & scl & q.sda & ~sda;
    assign bus_stop = q.scl & scl & ~q.sda & sda;
endmodule

// file: nvr_device.sv
/*
 device end: two-wire target holding three resistor settings with a
 nonvolatile copy, timed nonvolatile write and standby.
 assumes the host keeps the bus protocol; aresetn stands for power-on.
*/
module nvr_device import nvr_pkg::*; #(
    parameter bit THREE_SELECT = 1'b1,
    parameter logic [3:0] DEV_ID = DEV_ID_DEFAULT,
    parameter int NVW_CYCLES = NVW_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // two-wire bus
    nvr_i2c_if.device bus,
    // hard-wired select pins
    input wire logic select_pin_0,
    input wire logic select_pin_1,
    input wire logic select_pin_2,
    // resistor control
    output logic [NUM_RES-1:0][7:0] res_setting,
    output logic [NUM_RES-1:0][6:0] res_position,
    output logic [NUM_RES-1:0] res_high_impedance,
    output logic [NUM_RES-1:0] res_switch_low,
    // status
    output logic standby,
    output logic nv_write_busy
);
    localparam int TW = $clog2(NVW_CYCLES + 1);

    typedef struct packed {
        nvr_dstate_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [7:0] ptr;
        logic sda_oe;
        logic wr_pend;
        logic [TW-1:0] tmr;
        logic [NUM_RES-1:0][7:0] set;
    } nvr_dev_state_type;

    nvr_dev_state_type q;
    nvr_dev_state_type d;
    logic [NUM_RES-1:0][7:0] nvm_q = {NUM_RES{RES_DEFAULT}};
    logic wr_nv;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [2:0] sel;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == REG_RES0) || (a == REG_RES1) || (a == REG_RES2);
    endfunction

    function automatic logic [1:0] reg_idx(input logic [7:0] a);
        logic [7:0] diff;
        diff = a - REG_RES0;
        reg_idx = diff[1:0];
    endfunction

    nvr_line_cond u_cond (
        .aclk(aclk),
        .aresetn(aresetn),
        .scl(bus.scl),
        .sda(bus.sda),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .bus_start(bus_start),
        .bus_stop(bus_stop)
    );

    assign sel = THREE_SELECT ? {select_pin_2, select_pin_1, select_pin_0}
                              : {2'b00, select_pin_0};

    always_comb begin
        d = q;
        wr_nv = 1'b0;
        if (q.st == DS_NVW) begin
            // bus ignored, so polling sees no acknowledge
            if (q.tmr == TW'(NVW_CYCLES - 1)) begin
                d.st = DS_IDLE;
                wr_nv = 1'b1;
            end else begin
                d.tmr = q.tmr + 1'b1;
            end
        end else if (bus_stop) begin
            d.sda_oe = 1'b0;
            d.wr_pend = 1'b0;
            d.tmr = '0;
            d.st = q.wr_pend ? DS_NVW : DS_IDLE;
        end else if (bus_start) begin
            d.st = DS_ADDR;
            d.cnt = '0;
            d.sda_oe = 1'b0;
        end else if (scl_rise && q.cnt < CNT_ACK) begin
            unique case (q.st)
                DS_ADDR, DS_REG, DS_DATA: begin
                    d.sh = {q.sh[6:0], bus.sda};
                    d.cnt = q.cnt + 1'b1;
                end
                DS_TX: begin
                    d.cnt = q.cnt + 1'b1;
                end
                DS_IDLE, DS_HOLD, DS_NVW: begin
                end
            endcase
        end else if (scl_fall) begin
            if (q.cnt == CNT_ACK) begin
                unique case (q.st)
                    DS_ADDR: begin
                        if (q.sh[7:4] == DEV_ID && q.sh[3:1] == sel) begin
                            d.sda_oe = 1'b1;
                            d.rw = q.sh[0];
                            d.cnt = CNT_ACK_END;
                        end else begin
                            d.st = DS_IDLE;
                        end
                    end
                    DS_REG: begin
                        d.ptr = q.sh;
                        d.sda_oe = 1'b1;
                        d.cnt = CNT_ACK_END;
                    end
                    DS_DATA: begin
                        if (reg_hit(q.ptr)) begin
                            d.set[reg_idx(q.ptr)] = q.sh;
                            d.wr_pend = 1'b1;
                        end
                        d.sda_oe = 1'b1;
                        d.cnt = CNT_ACK_END;
                    end
                    DS_TX: begin
                        d.sda_oe = 1'b0;
                        d.st = DS_HOLD;
                    end
                    DS_IDLE, DS_HOLD, DS_NVW: begin
                    end
                endcase
            end else if (q.cnt == CNT_ACK_END) begin
                d.sda_oe = 1'b0;
                d.cnt = '0;
                unique case (q.st)
                    DS_ADDR: begin
                        if (q.rw == DIR_READ) begin
                            d.st = DS_TX;
                            d.sh = reg_hit(q.ptr) ? q.set[reg_idx(q.ptr)] : '0;
                            d.sda_oe = ~d.sh[7];
                        end else begin
                            d.st = DS_REG;
                        end
                    end
                    DS_REG: begin
                        d.st = DS_DATA;
                    end
                    DS_DATA: begin
                        d.st = DS_HOLD;
                    end
                    DS_IDLE, DS_TX, DS_HOLD, DS_NVW: begin
                    end
                endcase
            end else if (q.st == DS_TX && q.cnt != '0) begin
                d.sh = {q.sh[6:0], 1'b0};
                d.sda_oe = ~q.sh[6];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{st: DS_IDLE, cnt: '0, sh: '0, rw: DIR_WRITE, ptr: '0,
                   sda_oe: 1'b0, wr_pend: 1'b0, tmr: '0,
                   set: nvm_q};
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_nv) begin
            nvm_q <= q.set;
        end
    end

    for (genvar i = 0; i < NUM_RES; i++) begin : g_res
        assign res_position[i] = q.set[i][6:0];
        assign res_high_impedance[i] = q.set[i][HIZ_BIT];
        assign res_switch_low[i] = q.set[i] == SW_LOW_VALUE;
    end

    assign res_setting = q.set;
    assign standby = q.st == DS_IDLE;
    assign nv_write_busy = q.st == DS_NVW;
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = q.sda_oe;
endmodule

// file: nvr_host.sv
/*
 host end: two-wire bus master driven by software over AXI4-Lite.
 assumes one device on the bus and a quarter-bit time far above the clock.
*/
module nvr_host import nvr_pkg::*; #(
    parameter int QTR_CYCLES = QTR_CYCLES_DEFAULT,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // two-wire bus
    nvr_i2c_if.host bus
);
    localparam int DW = $clog2(QTR_CYCLES);

    typedef struct packed {
        logic busy, done, nack, retry, ack_bad, scl_oe, sda_oe;
        logic [2:0] step;
        logic [3:0] bitn;
        logic [1:0] qtr;
        logic [DW-1:0] div;
        logic [7:0] sh, rx;
        logic [31:0] cmd;
        logic aw_have, w_have, bvalid, rvalid;
        logic [AW-1:0] awaddr;
        logic [31:0] wdata, rdata;
        logic [3:0] wstrb;
        logic [1:0] bresp, rresp;
    } nvr_host_state_type;

    nvr_host_state_type q;
    nvr_host_state_type d;
    nvr_token_type tok;
    logic rd, rc, tick;

    function automatic nvr_token_type tok_of(input logic [2:0] s, input logic r,
                                             input logic c);
        tok_of = TK_TX;
        if (c) begin
            tok_of = (s == '0) ? TK_RECOV : (s == STEP_STOP_RC) ? TK_STOP : TK_START;
        end else if (s == '0 || (r && s == STEP_DATA)) begin
            tok_of = TK_START;
        end else if (s == (r ? STEP_STOP_RD : STEP_STOP_WR)) begin
            tok_of = TK_STOP;
        end else if (r && s == STEP_RX) begin
            tok_of = TK_RX;
        end
    endfunction

    function automatic logic [7:0] byte_of(input logic [2:0] s, input logic [31:0] c);
        logic [7:0] b;
        b = {DEV_ID_DEFAULT, c[CTRL_SEL_LSB +: 3], DIR_WRITE};
        if (s == STEP_REG) begin
            b = c[CTRL_REG_LSB +: 8];
        end else if (s == STEP_DATA) begin
            b = c[CTRL_DATA_LSB +: 8];
        end else if (s == STEP_RADDR) begin
            b[0] = DIR_READ;
        end
        byte_of = b;
    endfunction

    assign rd = q.cmd[CTRL_READ_BIT];
    assign rc = q.cmd[CTRL_RECOV_BIT];
    assign tok = tok_of(q.step, rd, rc);
    assign tick = q.div == DW'(QTR_CYCLES - 1);

    always_comb begin
        d = q;
        d.div = (tick || !q.busy) ? '0 : q.div + 1'b1;
        // register bus
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_SLVERR;
            if (q.awaddr == OFF_CTRL && !q.busy) begin
                for (int i = 0; i < 4; i++) begin
                    if (q.wstrb[i]) begin
                        d.cmd[i*8 +: 8] = q.wdata[i*8 +: 8];
                    end
                end
                d.bresp = RESP_OKAY;
                d.busy = 1'b1;
                d.done = 1'b0;
                d.nack = 1'b0;
                d.retry = 1'b0;
                d.step = '0;
                d.bitn = '0;
                d.qtr = '0;
                d.sda_oe = 1'b0;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (s_axi_araddr == OFF_CTRL) begin
                d.rdata = q.cmd;
            end else if (s_axi_araddr == OFF_STATUS) begin
                d.rdata[STAT_BUSY_BIT] = q.busy;
                d.rdata[STAT_DONE_BIT] = q.done;
                d.rdata[STAT_NACK_BIT] = q.nack;
                d.rdata[STAT_RDATA_LSB +: 8] = q.rx;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end
        // bit engine: four quarters per slot
        if (q.busy && tick) begin
            d.qtr = q.qtr + 1'b1;
            unique case (q.qtr)
                2'h0: begin
                    if (tok == TK_START) begin
                        d.sda_oe = 1'b0;
                    end else if (tok == TK_STOP) begin
                        d.sda_oe = 1'b1;
                    end else if (tok == TK_TX && q.bitn < CNT_ACK) begin
                        d.sda_oe = ~q.sh[7];
                    end else begin
                        d.sda_oe = 1'b0;
                    end
                end
                2'h1: begin
                    d.scl_oe = 1'b0;
                end
                2'h2: begin
                    if (tok == TK_START) begin
                        d.sda_oe = 1'b1;
                    end else if (tok == TK_STOP) begin
                        d.sda_oe = 1'b0;
                    end else if (q.bitn < CNT_ACK && tok != TK_RECOV) begin
                        d.rx = {q.rx[6:0], bus.sda};
                        d.sh = {q.sh[6:0], 1'b0};
                    end else begin
                        d.ack_bad = bus.sda;
                    end
                end
                2'h3: begin
                    if (tok != TK_STOP) begin
                        d.scl_oe = 1'b1;
                    end
                    d.bitn = q.bitn + 1'b1;
                    if (tok == TK_STOP) begin
                        d.step = '0;
                        d.busy = q.retry;
                        d.done = !q.retry;
                        d.retry = 1'b0;
                    end else if ((tok == TK_TX || tok == TK_RX) && q.bitn != CNT_ACK) begin
                    end else if (tok == TK_RECOV && !q.ack_bad && q.bitn != RECOV_LAST) begin
                    end else if (tok == TK_TX && q.ack_bad) begin
                        d.step = rd ? STEP_STOP_RD : STEP_STOP_WR;
                        d.bitn = '0;
                        if (q.step == STEP_ADDR && q.cmd[CTRL_POLL_BIT]) begin
                            d.retry = 1'b1;
                        end else begin
                            d.nack = 1'b1;
                        end
                    end else begin
                        d.step = q.step + 1'b1;
                        d.bitn = '0;
                        d.sh = byte_of(d.step, q.cmd);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = ~q.aw_have & ~q.bvalid;
    assign s_axi_wready = ~q.w_have & ~q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = q.scl_oe;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = q.sda_oe;
endmodule

// file: nvr_asserts.sv
/*
 bus checker for the two-wire link between host and device.
 assumes the wired line levels and the device data enable of the shared interface.
*/
module nvr_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_start; scl && $past(scl) && !sda && $past(sda); endsequence
    sequence s_stop; scl && $past(scl) && sda && !$past(sda); endsequence
    sequence s_rise; scl && !$past(scl); endsequence
    // clock rises since the last start, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_q <= 4'hF;
        else if (scl && $past(scl) && !sda && $past(sda))
            cnt_q <= 4'h0;
        else if (scl && !$past(scl) && cnt_q != 4'hF)
            cnt_q <= cnt_q + 4'h1;
    end
    property p_on_low; $rose(sda_s_oe) |-> !scl; endproperty
    property p_off_low; $fell(sda_s_oe) |-> !scl; endproperty
    property p_steady; scl && $past(scl) |-> $stable(sda_s_oe); endproperty
    property p_start; s_start |-> !sda_s_oe; endproperty
    property p_stop; s_stop |=> !sda_s_oe [*4]; endproperty
    property p_hold; $rose(sda_s_oe) |-> sda_s_oe throughout (##[1:40] s_rise); endproperty
    property p_addr; s_rise and (cnt_q < 4'h8) |-> !sda_s_oe; endproperty
    property p_slot; $rose(sda_s_oe) && cnt_q < 4'h9 |-> cnt_q == 4'h8; endproperty
    a_on_low: assert property (p_on_low)
        else $error("device drive began with clock high");
    a_off_low: assert property (p_off_low)
        else $error("device drive ended with clock high");
    a_steady: assert property (p_steady)
        else $error("device data changed while clock high");
    a_start: assert property (p_start)
        else $error("start seen while device drives data");
    a_stop: assert property (p_stop)
        else $error("device drove data right after stop");
    a_hold: assert property (p_hold)
        else $error("acknowledge not held over its clock pulse");
    a_addr: assert property (p_addr)
        else $error("device drove data during address bits");
    a_slot: assert property (p_slot)
        else $error("first acknowledge outside the ninth slot");
endmodule

// file: nvr_resistor_i2c_slave_bench.sv
/*
 self-checking bench: host and device joined by the two-wire interface.
 assumes host registers over AXI4-Lite and shortened bit and write timings.
*/
module nvr_resistor_i2c_slave_bench import nvr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, st;
    logic [2:0] pins = 3'h5;
    logic [NUM_RES-1:0][7:0] res_setting;
    logic [NUM_RES-1:0][6:0] res_position;
    logic [NUM_RES-1:0] res_high_impedance, res_switch_low;
    logic standby, nv_write_busy;
    int mismatches = 0, tests_run = 0;
    logic [7:0] row_reg [4] = '{8'hF8, 8'hF9, 8'hFA, 8'hF8};
    logic [7:0] row_dat [4] = '{8'h00, 8'h80, 8'h3C, 8'hFF};

    nvr_i2c_if u_nvr_i2c_if ();
    nvr_device #(.NVW_CYCLES(200)) u_nvr_device (.aclk(aclk), .aresetn(aresetn),
        .bus(u_nvr_i2c_if), .select_pin_0(pins[0]), .select_pin_1(pins[1]),
        .select_pin_2(pins[2]), .res_setting(res_setting), .res_position(res_position),
        .res_high_impedance(res_high_impedance), .res_switch_low(res_switch_low),
        .standby(standby), .nv_write_busy(nv_write_busy));
    nvr_host #(.QTR_CYCLES(4)) u_nvr_host (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(u_nvr_i2c_if));
    nvr_asserts u_nvr_asserts (.aclk(aclk), .aresetn(aresetn), .scl(u_nvr_i2c_if.scl),
        .sda(u_nvr_i2c_if.sda), .sda_s_oe(u_nvr_i2c_if.sda_s_oe));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
        while (bvalid !== 1'b1) @(posedge aclk);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rsp = rresp;
        st = rdata;
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(logic [7:0] r, logic [7:0] d, logic [2:0] s,
                                        logic rd, logic poll);
        return {10'h0, poll, rd, 1'b0, s, r, d};
    endfunction
    task automatic cmd(input logic [31:0] c);
        axi_wr(OFF_CTRL, c);
        chk("ctrl bresp", 32'(RESP_OKAY), 32'(rsp));
        do axi_rd(OFF_STATUS); while (st[STAT_BUSY_BIT] === 1'b1);
    endtask

    initial begin
        forever #2 aclk = ~aclk;
    end
    initial begin
        #160000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < NUM_RES; i++) chk("reset setting", 32'h7F, 32'(res_setting[i]));
        chk("reset standby", 32'h1, 32'(standby));
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            int k;
            k = int'(row_reg[i] - REG_RES0);
            cmd(ctl(row_reg[i], row_dat[i], 3'h5, 1'b0, 1'b1));
            chk("setting", 32'(row_dat[i]), 32'(res_setting[k]));
            chk("position", 32'(row_dat[i][6:0]), 32'(res_position[k]));
            chk("high impedance", 32'(row_dat[i][7]), 32'(res_high_impedance[k]));
            chk("switch low", 32'(row_dat[i] == 8'h00), 32'(res_switch_low[k]));
            chk("timed write", 32'h1, 32'(nv_write_busy));
            cmd(ctl(row_reg[i], 8'h00, 3'h5, 1'b1, 1'b1));
            chk("read back", 32'(row_dat[i]), 32'(st[15:8]));
            chk("read nack", 32'h0, 32'(st[STAT_NACK_BIT]));
            chk("standby", 32'h1, 32'(standby));
            $display("test row %0d done", i);
        end
        cmd(ctl(REG_RES1, 8'h11, 3'h5, 1'b0, 1'b1));
        cmd(ctl(REG_RES1, 8'h22, 3'h5, 1'b0, 1'b0));
        chk("busy nack", 32'h1, 32'(st[STAT_NACK_BIT]));
        chk("busy ignored", 32'h11, 32'(res_setting[1]));
        while (nv_write_busy === 1'b1) @(posedge aclk);
        chk("standby after write", 32'h1, 32'(standby));
        $display("test busy refusal done");
        cmd(ctl(REG_RES0, 8'h55, 3'h0, 1'b0, 1'b0));
        chk("select nack", 32'h1, 32'(st[STAT_NACK_BIT]));
        chk("select ignored", 32'hFF, 32'(res_setting[0]));
        chk("select standby", 32'h1, 32'(standby));
        pins <= 3'h2;
        cmd(ctl(REG_RES0, 8'h55, 3'h2, 1'b0, 1'b1));
        chk("select match nack", 32'h0, 32'(st[STAT_NACK_BIT]));
        chk("select match", 32'h55, 32'(res_setting[0]));
        axi_wr(OFF_CTRL, ctl(REG_RES2, 8'h00, 3'h2, 1'b1, 1'b1));
        axi_wr(OFF_CTRL, 32'h0);
        chk("busy ctrl write", 32'(RESP_SLVERR), 32'(rsp));
        do axi_rd(OFF_STATUS); while (st[STAT_BUSY_BIT] === 1'b1);
        chk("polled read", 32'h3C, 32'(st[15:8]));
        axi_rd(OFF_CTRL);
        chk("ctrl resp", 32'(RESP_OKAY), 32'(rsp));
        chk("ctrl kept", ctl(REG_RES2, 8'h00, 3'h2, 1'b1, 1'b1), st);
        cmd(32'h1 << CTRL_RECOV_BIT);
        chk("recovery done", 32'h1, 32'(st[STAT_DONE_BIT]));
        axi_rd(4'h8);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
        axi_wr(4'hC, 32'h0);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
        $display("test address and recovery done");
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("kept setting 0", 32'h55, 32'(res_setting[0]));
        chk("kept setting 1", 32'h11, 32'(res_setting[1]));
        chk("kept setting 2", 32'h3C, 32'(res_setting[2]));
        $display("test power cycle done");
        end_sim();
    end
endmodule
